// >>> pkg/pwm_dac_pkg.sv
// shared constants and types for the dual pulse-width D/A block
package pwm_dac_pkg;

  // timing in oscillator clocks; mclk is the oscillator clock
  localparam int FINE_PERIOD_CLKS = 32768;
  localparam int FINE_SUBPERIODS = 64;
  localparam int FINE_SUB_CLKS = FINE_PERIOD_CLKS / FINE_SUBPERIODS;
  localparam int COARSE_PERIOD_CLKS = 128;
  localparam int UNIT_CLKS = 2;

  localparam int FINE_CNT_W = $clog2(FINE_PERIOD_CLKS);
  localparam int FINE_SLOT_W = $clog2(FINE_SUB_CLKS);
  localparam int COARSE_CNT_W = $clog2(COARSE_PERIOD_CLKS);
  localparam int FINE_VAL_W = 14;
  localparam int COARSE_VAL_W = 6;
  localparam int SPREAD_W = 6;

  // register byte addresses on the AXI4-Lite bus
  localparam logic [3:0] ADDR_SELECTOR = 4'h0;
  localparam logic [3:0] ADDR_TRANSFER = 4'h4;
  localparam logic [3:0] ADDR_FINE_STATUS = 4'h8;
  localparam logic [3:0] ADDR_COARSE_STATUS = 4'hC;

  // buffer selector codes
  localparam logic [3:0] SEL_FINE_MID = 4'h2;
  localparam logic [3:0] SEL_FINE_HIGH = 4'h3;
  localparam logic [3:0] SEL_FINE_LOW = 4'h4;
  localparam logic [3:0] SEL_FINE_SPREAD = 4'h5;
  localparam logic [3:0] SEL_COARSE_LOW = 4'h6;
  localparam logic [3:0] SEL_COARSE_HIGH = 4'h7;
  localparam logic [3:0] SEL_TRANSFER = 4'hC;

  // field positions inside the fine and coarse values
  localparam int FINE_LOW_LSB = 0;
  localparam int FINE_SPREAD_LSB = 4;
  localparam int FINE_MID_LSB = 6;
  localparam int FINE_HIGH_LSB = 10;
  localparam int COARSE_HIGH_LSB = 4;

  // status layout
  localparam int STAT_PENDING_BIT = 31;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [FINE_VAL_W-1:0] fine;
    logic [COARSE_VAL_W-1:0] coarse;
  } pwm_values_t;

  localparam pwm_values_t VALUES_RESET = '0;

endpackage

// >>> verilog/pwm_period_timer.sv
// free-running period counter with one active-low pulse per compare interval
module pwm_period_timer #(
  parameter int CNT_W = 15,
  parameter int SLOT_W = 9
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // control
  input wire logic clear,
  input wire logic [SLOT_W-1:0] width,
  // status
  output logic [CNT_W-1:0] count,
  output logic period_end,
  output logic pulse_n
);

  logic [CNT_W-1:0] next_count;
  logic next_pulse_n;
  logic [SLOT_W-1:0] unit_index;

  generate
    if (SLOT_W < 2 || SLOT_W > CNT_W) begin : g_bad
      $error("pwm_period_timer: SLOT_W out of range");
    end
  endgenerate

  assign period_end = &count;

  always_comb begin
    // one unit is two clocks, so the low counter bit is dropped
    unit_index = {1'b0, count[SLOT_W-1:1]};
    next_count = count + 1'b1;
    next_pulse_n = !(unit_index < width);
    if (clear) begin
      next_count = '0;
      next_pulse_n = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= '0;
      pulse_n <= 1'b1;
    end else begin
      count <= next_count;
      pulse_n <= next_pulse_n;
    end
  end

endmodule

// >>> verilog/pwm_dac.sv
// dual pulse-width D/A outputs with nibble transfer buffer and AXI4-Lite access
// Functional notes
// - The fine output runs from a 14-bit value over a 2^15-clock period split into 64 sub-periods.
// - Each fine sub-period carries a low pulse of n units of 2 clocks, n being value bits 13-6.
// - The fine pulse grows by one unit in exactly m of the 64 sub-periods, m being bits 5-0.
// - Extra units go to sub-period 32 for bit 0, 16/48 for bit 1, down to all odd ones for bit 5.
// - The coarse output has one pulse of k units per 2^7-clock period, k being its 6-bit value.
// - Sections 2, 3, 4, 5 load fine bits 9-6, 13-10, 3-0 and 5-4 (two low nibble bits only).
// - Sections 6 and 7 load coarse bits 3-0 and 5-4.
// - Writing code C to the selector commits the transfer buffer and enables the new values.
// - While sections are being written the outputs keep using the committed values.
// - New values take effect at the next period boundary of each output.
// - Committed values stay until a later commit, a hold or a reset replaces them.
// - Reset and hold clear selector, buffer and committed values, leaving both outputs high.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
module pwm_dac (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // hold request pin, asynchronous
  input wire logic hold_req,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pulse outputs, active low
  output logic fine_pulse_output_n,
  output logic coarse_pulse_output_n
);
  import pwm_dac_pkg::*;

  // hold synchroniser
  logic hold_meta;
  logic hold_sync;

  // bus slave state
  logic aw_full;
  logic [3:0] aw_addr;
  logic w_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [1:0] bresp;
  logic bvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic next_aw_full;
  logic [3:0] next_aw_addr;
  logic next_w_full;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;

  // transfer state
  logic [3:0] selector;
  pwm_values_t xfer_buf;
  pwm_values_t committed;
  pwm_values_t active;
  logic fine_pending;
  logic coarse_pending;
  logic [3:0] next_selector;
  pwm_values_t next_xfer_buf;
  pwm_values_t next_committed;
  pwm_values_t next_active;
  logic next_fine_pending;
  logic next_coarse_pending;

  // waveform side
  logic [FINE_CNT_W-1:0] fine_count;
  logic [COARSE_CNT_W-1:0] coarse_count;
  logic fine_end;
  logic coarse_end;
  logic [FINE_SLOT_W-1:0] fine_width;
  logic [COARSE_CNT_W-1:0] coarse_width;
  logic do_write;
  logic commit_now;
  logic nibble_ok;
  logic [3:0] nibble;

  generate
    if (FINE_CNT_W - FINE_SLOT_W != SPREAD_W) begin : g_bad_fine
      $error("pwm_dac: fine period must hold 64 sub-periods");
    end
  endgenerate

  // true when sub-period slot gets the extra unit for spread value m
  function automatic logic extra_slot(input logic [SPREAD_W-1:0] slot,
                                      input logic [SPREAD_W-1:0] m);
    logic hit;
    hit = 1'b0;
    // lowest set bit position p of the slot selects m bit 5-p; slot 0 never gets one
    for (int p = SPREAD_W - 1; p >= 0; p--) begin
      if (slot[p]) begin
        hit = m[SPREAD_W-1-p];
      end
    end
    return hit;
  endfunction

  // decode of a word address inside the map
  function automatic logic is_addr(input logic [3:0] addr, input logic [3:0] reg_addr);
    return addr[3:2] == reg_addr[3:2];
  endfunction

  // hold is a pin, two flops before use
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_meta <= 1'b0;
      hold_sync <= 1'b0;
    end else begin
      hold_meta <= hold_req;
      hold_sync <= hold_meta;
    end
  end

  // ---------------- bus slave ----------------
  assign s_axi_awready = !aw_full && !bvalid;
  assign s_axi_wready = !w_full && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;

  assign do_write = aw_full && w_full && !bvalid;
  assign nibble = w_data[3:0];

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      if (is_addr(aw_addr, ADDR_SELECTOR) || is_addr(aw_addr, ADDR_TRANSFER)) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      // write-only registers read as zero
      if (is_addr(s_axi_araddr, ADDR_FINE_STATUS)) begin
        next_rdata[FINE_VAL_W-1:0] = committed.fine;
        next_rdata[STAT_PENDING_BIT] = fine_pending;
      end else if (is_addr(s_axi_araddr, ADDR_COARSE_STATUS)) begin
        next_rdata[COARSE_VAL_W-1:0] = committed.coarse;
        next_rdata[STAT_PENDING_BIT] = coarse_pending;
      end else if (!is_addr(s_axi_araddr, ADDR_SELECTOR)
                   && !is_addr(s_axi_araddr, ADDR_TRANSFER)) begin
        next_rresp = RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ---------------- transfer buffer and latches ----------------
  // only byte lane 0 carries the nibble
  assign nibble_ok = do_write && w_strb[0];
  assign commit_now = nibble_ok && is_addr(aw_addr, ADDR_SELECTOR)
                      && (nibble == SEL_TRANSFER);

  always_comb begin
    next_selector = selector;
    next_xfer_buf = xfer_buf;
    next_committed = committed;
    next_active = active;
    next_fine_pending = fine_pending;
    next_coarse_pending = coarse_pending;
    if (nibble_ok && is_addr(aw_addr, ADDR_SELECTOR)) begin
      next_selector = nibble;
    end
    if (nibble_ok && is_addr(aw_addr, ADDR_TRANSFER)) begin
      unique case (selector)
        SEL_FINE_MID: next_xfer_buf.fine[FINE_MID_LSB+:4] = nibble;
        SEL_FINE_HIGH: next_xfer_buf.fine[FINE_HIGH_LSB+:4] = nibble;
        SEL_FINE_LOW: next_xfer_buf.fine[FINE_LOW_LSB+:4] = nibble;
        SEL_FINE_SPREAD: next_xfer_buf.fine[FINE_SPREAD_LSB+:2] = nibble[1:0];
        SEL_COARSE_LOW: next_xfer_buf.coarse[3:0] = nibble;
        SEL_COARSE_HIGH: next_xfer_buf.coarse[COARSE_HIGH_LSB+:2] = nibble[1:0];
        default: next_xfer_buf = xfer_buf;
      endcase
    end
    // committed only changes on the transfer code or on hold
    if (commit_now) begin
      next_committed = xfer_buf;
    end
    // outputs follow the active copy, reloaded only at a period boundary
    if (fine_end) begin
      next_active.fine = next_committed.fine;
      next_fine_pending = 1'b0;
    end else if (commit_now) begin
      next_fine_pending = 1'b1;
    end
    if (coarse_end) begin
      next_active.coarse = next_committed.coarse;
      next_coarse_pending = 1'b0;
    end else if (commit_now) begin
      next_coarse_pending = 1'b1;
    end
    if (hold_sync) begin
      next_selector = '0;
      next_xfer_buf = VALUES_RESET;
      next_committed = VALUES_RESET;
      next_active = VALUES_RESET;
      next_fine_pending = 1'b0;
      next_coarse_pending = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      selector <= '0;
      xfer_buf <= VALUES_RESET;
      committed <= VALUES_RESET;
      active <= VALUES_RESET;
      fine_pending <= 1'b0;
      coarse_pending <= 1'b0;
    end else begin
      selector <= next_selector;
      xfer_buf <= next_xfer_buf;
      committed <= next_committed;
      active <= next_active;
      fine_pending <= next_fine_pending;
      coarse_pending <= next_coarse_pending;
    end
  end

  // ---------------- waveforms ----------------
  // pulse width in units: n plus one in the chosen sub-periods, up to a full sub-period
  always_comb begin
    fine_width = {1'b0, active.fine[FINE_VAL_W-1:SPREAD_W]}
                 + {{(FINE_SLOT_W-1){1'b0}},
                    extra_slot(fine_count[FINE_CNT_W-1:FINE_SLOT_W],
                               active.fine[SPREAD_W-1:0])};
    coarse_width = {1'b0, active.coarse};
  end

  pwm_period_timer #(
    .CNT_W(FINE_CNT_W),
    .SLOT_W(FINE_SLOT_W)
  ) u_fine (
    .mclk(mclk),
    .reset(reset),
    .clear(hold_sync),
    .width(fine_width),
    .count(fine_count),
    .period_end(fine_end),
    .pulse_n(fine_pulse_output_n)
  );

  pwm_period_timer #(
    .CNT_W(COARSE_CNT_W),
    .SLOT_W(COARSE_CNT_W)
  ) u_coarse (
    .mclk(mclk),
    .reset(reset),
    .clear(hold_sync),
    .width(coarse_width),
    .count(coarse_count),
    .period_end(coarse_end),
    .pulse_n(coarse_pulse_output_n)
  );

endmodule

// >>> bench/pwm_filter_model.sv
// low-pass filter stand-in: counts low cycles at the pin between two sample strobes
module pwm_filter_model (
  // clock
  input wire logic mclk,
  // pulse from the block and window strobe
  input wire logic pulse_n,
  input wire logic sample,
  // low cycles seen in the last window
  output logic [15:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin_latch = 1'b1;
  logic [15:0] acc;
  // pin pulled low by either the latch or the pulse
  wire logic pin_n = pulse_n & pin_latch;
  always_ff @(posedge mclk) begin
    if (sample) begin
      level <= acc;
      acc <= {15'h0, ~pin_n};
    end else begin
      acc <= acc + {15'h0, ~pin_n};
    end
  end
endmodule

// >>> bench/pwm_dac_assertions.sv
// port-level checker for the dual pulse-width D/A block
module pwm_dac_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic hold_req,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // outputs
  input wire logic fine_pulse_output_n,
  input wire logic coarse_pulse_output_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_dac_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // longest coarse low stretch, 63 units of 2 clocks
  logic [7:0] low_run;
  always_ff @(posedge mclk) begin
    low_run <= (reset || coarse_pulse_output_n) ? 8'h0 : low_run + 8'h1;
  end
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rresp == RESP_OKAY) else $error("read not answered");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_reset_idle: assert property ($fell(reset) |-> fine_pulse_output_n
    && coarse_pulse_output_n) else $error("outputs not idle after reset");
  a_hold_clears: assert property (hold_req [*6] |-> fine_pulse_output_n
    && coarse_pulse_output_n) else $error("outputs not idle in hold");
  a_coarse_width: assert property (low_run <= 8'h7E)
    else $error("coarse pulse too long");
endmodule
bind pwm_dac pwm_dac_assertions chk_i (.mclk(mclk), .reset(reset), .hold_req(hold_req),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .fine_pulse_output_n(fine_pulse_output_n), .coarse_pulse_output_n(coarse_pulse_output_n));

// >>> bench/testbench.sv
// self-checking bench for the dual pulse-width D/A block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_dac_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, hold_req = 1'b0, sample = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fine_n, coarse_n;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] fine_lvl, coarse_lvl;
  pwm_values_t cur, nv;
  int fail_count = 0;
  int tests_run = 0;
  always #4 mclk = ~mclk;
  pwm_dac DUT (.mclk(mclk), .reset(reset), .hold_req(hold_req), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fine_pulse_output_n(fine_n), .coarse_pulse_output_n(coarse_n));
  pwm_filter_model fine_filter (.mclk(mclk), .pulse_n(fine_n), .sample(sample),
    .level(fine_lvl));
  pwm_filter_model coarse_filter (.mclk(mclk), .pulse_n(coarse_n), .sample(sample),
    .level(coarse_lvl));
  function automatic logic [31:0] fine_low(input pwm_values_t v);
    return {17'h0, v.fine[13:6], 7'h0} + {25'h0, v.fine[5:0], 1'b0};
  endfunction
  function automatic logic [31:0] coarse_low(input pwm_values_t v);
    return {25'h0, v.coarse, 1'b0};
  endfunction
  function automatic logic [3:0] nib(input pwm_values_t v, input logic [3:0] s);
    case (s)
      SEL_FINE_MID: return v.fine[9:6];
      SEL_FINE_HIGH: return v.fine[13:10];
      SEL_FINE_LOW: return v.fine[3:0];
      SEL_FINE_SPREAD: return {2'h0, v.fine[5:4]};
      SEL_COARSE_LOW: return v.coarse[3:0];
      default: return {2'h0, v.coarse[5:4]};
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // each channel released only once its own ready was seen
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rready <= 1'b0;
  endtask
  task automatic load(input pwm_values_t v);
    for (int s = 2; s < 8; s++) begin
      wr(ADDR_SELECTOR, 32'(s), resp);
      wr(ADDR_TRANSFER, {28'h0, nib(v, 4'(s))}, resp);
    end
  endtask
  // window of exactly n cycles for both filters
  task automatic measure(input int n);
    @(posedge mclk); sample <= 1'b1;
    @(posedge mclk); sample <= 1'b0;
    repeat (n - 1) @(posedge mclk);
    sample <= 1'b1;
    @(posedge mclk); sample <= 1'b0;
    @(posedge mclk);
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    results();
  end
  initial begin
    void'($urandom(32'h31e5));
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    cur = VALUES_RESET;
    rd_reg(ADDR_FINE_STATUS, rd); chk(rd, 32'h0, "fine_status_reset");
    rd_reg(ADDR_COARSE_STATUS, rd); chk(rd, 32'h0, "coarse_status_reset");
    chk({31'h0, fine_n & coarse_n}, 32'h1, "idle_outputs");
    for (int i = 0; i < 6; i++) begin
      nv = (i == 0) ? '1 : (i == 1) ? '0 : pwm_values_t'($urandom);
      load(nv);
      rd_reg(ADDR_FINE_STATUS, rd); chk(rd & 32'h3FFF, 32'(cur.fine), "fine_early");
      wr(ADDR_SELECTOR, {28'h0, SEL_TRANSFER}, resp);
      cur = nv;
      rd_reg(ADDR_FINE_STATUS, rd); chk(rd & 32'h3FFF, 32'(cur.fine), "fine_value");
      rd_reg(ADDR_COARSE_STATUS, rd); chk(rd & 32'h3F, 32'(cur.coarse), "coarse_value");
      repeat (512) @(posedge mclk);
      rd_reg(ADDR_COARSE_STATUS, rd); chk(rd, 32'(cur.coarse), "coarse_adopted");
      measure(128); chk(32'(coarse_lvl), coarse_low(cur), "coarse_low_time");
    end
    for (int s = 0; s < 16; s++) if (s < 2 || (s > 7 && s != 12)) begin
      wr(ADDR_SELECTOR, 32'(s), resp);
      wr(ADDR_TRANSFER, 32'hF, resp);
    end
    wr(ADDR_SELECTOR, {28'h0, SEL_TRANSFER}, resp);
    rd_reg(ADDR_FINE_STATUS, rd); chk(rd & 32'h3FFF, 32'(cur.fine), "stray_sel");
    rd_reg(ADDR_COARSE_STATUS, rd); chk(rd & 32'h3F, 32'(cur.coarse), "stray_coarse");
    wr(ADDR_FINE_STATUS, 32'h0, resp); chk(32'(resp), 32'(RESP_SLVERR), "ro_resp");
    rd_reg(ADDR_FINE_STATUS, rd); chk(rd & 32'h3FFF, 32'(cur.fine), "fine_kept");
    rd_reg(ADDR_SELECTOR, rd); chk(rd, 32'h0, "selector_read");
    nv = pwm_values_t'($urandom);
    load(nv);
    // transfer code with lane 0 disabled must not commit
    wstrb <= 4'h0;
    wr(ADDR_SELECTOR, {28'h0, SEL_TRANSFER}, resp);
    wstrb <= 4'hF;
    rd_reg(ADDR_FINE_STATUS, rd); chk(rd & 32'h3FFF, 32'(cur.fine), "no_strobe");
    wr(ADDR_SELECTOR, {28'h0, SEL_TRANSFER}, resp);
    cur = nv;
    // new fine data is in use within one full period
    repeat (32800) @(posedge mclk);
    measure(32768); chk(32'(fine_lvl), fine_low(cur), "fine_low_time");
    chk(32'(coarse_lvl), 256 * coarse_low(cur), "coarse_long");
    rd_reg(ADDR_FINE_STATUS, rd); chk(rd, 32'(cur.fine), "fine_adopted");
    hold_req <= 1'b1;
    repeat (8) @(posedge mclk);
    hold_req <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({31'h0, fine_n & coarse_n}, 32'h1, "hold_outputs");
    rd_reg(ADDR_FINE_STATUS, rd); chk(rd, 32'h0, "hold_status");
    results();
  end
endmodule
